// >>> clock_timer_seconds_counter.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module clock_timer_seconds_counter
  import clock_timer_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  // CPU interrupt mask level
  input wire logic cpu_mask_bit_low,
  input wire logic cpu_mask_bit_high,
  // Interrupt request
  output irq_out_t irq_out
);

  localparam int unsigned TW = $clog2(TICK_CYCLES_P + 1);

  logic [TW-1:0] tick_cnt_q;
  logic tick_q;
  apb_rsp_t rsp_q;
  irq_out_t irq_q;
  logic [1:0] prio_q;
  logic [SRC_N-1:0] en_q;
  logic [SRC_N-1:0] pend_q;
  logic run_req_q;
  logic running_q;
  logic [7:0] div_q;
  logic [3:0] units_q;
  logic [2:0] tens_q;

  logic [15:0] idx;
  logic hit_prio, hit_en, hit_pend, hit_ctl, hit_div, hit_sec, mapped;
  logic setup, wr_acc;
  logic wr_prio, wr_en, wr_pend, wr_ctl, wr_rst, wr_sec;
  logic clr_div, adv, wrap;
  logic [7:0] fall;
  logic [7:0] rd_byte;
  logic [SRC_N-1:0] src_set;
  logic [SRC_N-1:0] pend_clr;
  logic [1:0] cpu_mask;
  logic carry;

  assign cpu_mask = {cpu_mask_bit_high, cpu_mask_bit_low};
  assign apb_rsp = rsp_q;
  assign irq_out = irq_q;

  // Free-running tick, so run/stop always syncs within one tick period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TW'(TICK_CYCLES_P - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Address decode
  assign idx = apb_req.paddr[ADDR_W-1:2];
  assign hit_prio = (idx == IDX_PRIO);
  assign hit_en = (idx == IDX_ENABLE);
  assign hit_pend = (idx == IDX_PENDING);
  assign hit_ctl = (idx == IDX_CTRL);
  assign hit_div = (idx == IDX_DIV);
  assign hit_sec = (idx == IDX_SEC);
  assign mapped = hit_prio | hit_en | hit_pend | hit_ctl | hit_div | hit_sec;

  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite
                  & rsp_q.pready;
  assign wr_prio = wr_acc & hit_prio;
  assign wr_en = wr_acc & hit_en;
  assign wr_pend = wr_acc & hit_pend;
  assign wr_ctl = wr_acc & hit_ctl;
  assign wr_rst = wr_ctl & apb_req.pwdata[RST_BIT];
  assign wr_sec = wr_acc & hit_sec;

  // Read mux; unused bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_prio) begin
      rd_byte[PRIO_LSB +: 2] = prio_q;
    end else if (hit_en) begin
      rd_byte[SRC_LSB +: SRC_N] = en_q;
    end else if (hit_pend) begin
      rd_byte[SRC_LSB +: SRC_N] = pend_q;
    end else if (hit_ctl) begin
      // Reset bit is write-only and reads zero
      rd_byte[RUN_BIT] = run_req_q | running_q;
    end else if (hit_div) begin
      rd_byte = div_q;
    end else if (hit_sec) begin
      rd_byte[SEC_MSB:0] = {tens_q, units_q};
    end
  end

  // Zero-wait slave: answer is ready in the first access cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready <= setup;
      rsp_q.pslverr <= setup & ~mapped;
      if (setup) begin
        rsp_q.prdata <= apb_req.pwrite ? '0 : DATA_W'(rd_byte);
      end
    end
  end

  // Priority and enables
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prio_q <= PRIO_RST;
    end else if (wr_prio) begin
      prio_q <= apb_req.pwdata[PRIO_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_q <= '0;
    end else if (wr_en) begin
      en_q <= apb_req.pwdata[SRC_LSB +: SRC_N];
    end
  end

  // Run request and the state actually in force
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_req_q <= 1'b0;
    end else if (wr_ctl) begin
      run_req_q <= apb_req.pwdata[RUN_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      running_q <= 1'b0;
    end else if (tick_q) begin
      running_q <= run_req_q;
    end
  end

  // A clearing write beats a tick in the same cycle
  assign clr_div = wr_rst | wr_sec;
  // Old run state decides, so a stop still lets one more count through
  assign adv = tick_q & running_q & ~clr_div;

  // Falling edge of stage i: all lower stages roll over together
  always_comb begin
    carry = adv;
    fall = 8'h00;
    for (int i = 0; i < 8; i++) begin
      carry = carry & div_q[i];
      fall[i] = carry;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= DIV_RST;
    end else if (clr_div) begin
      div_q <= DIV_RST;
    end else if (adv) begin
      div_q <= div_q + 1'b1;
    end
  end

  // Seconds in BCD
  assign wrap = fall[TAP_1HZ] & (units_q == UNITS_MAX)
                & (tens_q == TENS_MAX);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      units_q <= UNITS_RST;
      tens_q <= TENS_RST;
    end else if (wr_rst) begin
      units_q <= UNITS_RST;
      tens_q <= TENS_RST;
    end else if (wr_sec) begin
      // Out-of-range presets count on without correction
      units_q <= apb_req.pwdata[3:0];
      tens_q <= apb_req.pwdata[SEC_MSB:4];
    end else if (fall[TAP_1HZ]) begin
      if (units_q == UNITS_MAX) begin
        units_q <= UNITS_RST;
        if (tens_q == TENS_MAX) begin
          tens_q <= TENS_RST;
        end else begin
          tens_q <= tens_q + 1'b1;
        end
      end else begin
        units_q <= units_q + 1'b1;
      end
    end
  end

  // Pending flags: a new event wins over a clear in the same cycle
  assign src_set = {wrap, fall[TAP_1HZ], fall[TAP_2HZ], fall[TAP_8HZ],
                    fall[TAP_32HZ]};
  assign pend_clr = wr_pend ? apb_req.pwdata[SRC_LSB +: SRC_N] : '0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | src_set;
    end
  end

  // Interrupt request to the CPU
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_q.req <= 1'b0;
      irq_q.level <= PRIO_RST;
      irq_q.vector <= VECTOR_ADDR;
    end else begin
      irq_q.req <= (|(pend_q & en_q)) & (prio_q > cpu_mask);
      irq_q.level <= prio_q;
      irq_q.vector <= VECTOR_ADDR;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_timer_reset_clears: assert property (
    wr_rst |=> (div_q == DIV_RST) && (units_q == UNITS_RST)
               && (tens_q == TENS_RST))
    else $error("timer reset did not clear divider and seconds");

  a_preset_loads: assert property (
    wr_sec |=> ({tens_q, units_q} == $past(apb_req.pwdata[SEC_MSB:0]))
               && (div_q == DIV_RST))
    else $error("seconds preset not loaded or divider not cleared");

  a_hold_when_stopped: assert property (
    (!running_q && !clr_div) |=> $stable(div_q))
    else $error("divider moved while stopped");

  a_run_sync_tick: assert property (
    !tick_q |=> $stable(running_q))
    else $error("run state changed away from a tick");

  a_stop_plus_one: assert property (
    (tick_q && running_q && !run_req_q && !clr_div)
    |=> (div_q == 8'($past(div_q) + 1'b1)) && !running_q)
    else $error("stop did not allow one final count");

  a_run_reads_one: assert property (
    (setup && hit_ctl && !apb_req.pwrite && running_q)
    |=> rsp_q.prdata[RUN_BIT])
    else $error("run bit read zero before the timer stopped");

  a_pend_32hz_set: assert property (
    fall[TAP_32HZ] |=> pend_q[0])
    else $error("32 Hz pending flag not set on falling edge");

  a_minute_wrap: assert property (
    wrap |=> (units_q == UNITS_RST) && (tens_q == TENS_RST)
             && pend_q[SRC_N-1])
    else $error("seconds wrap did not zero counter and flag it");

  a_irq_masked: assert property (
    (prio_q <= cpu_mask) |=> !irq_q.req)
    else $error("request raised at or below the CPU mask level");

  a_pend_w1c: assert property (
    (wr_pend && apb_req.pwdata[SRC_LSB] && !src_set[0]) |=> !pend_q[0])
    else $error("write one did not clear the pending flag");

  a_div_read_only: assert property (
    (wr_acc && hit_div && !adv) |=> $stable(div_q))
    else $error("write to divider readout changed it");

  a_sec_top_zero: assert property (
    (setup && hit_sec && !apb_req.pwrite) |=> !rsp_q.prdata[7])
    else $error("seconds readout bit 7 not zero");

  // Counting, register, flag and request checks
  a_div_advance: assert property (
    adv |=> (div_q == 8'($past(div_q) + 1'b1)))
    else $error("divider did not advance on a running tick");

  a_run_write: assert property (
    wr_ctl |=> (run_req_q == $past(apb_req.pwdata[RUN_BIT])))
    else $error("run request bit not taken from the write");

  a_start_at_tick: assert property (
    (tick_q && run_req_q) |=> running_q)
    else $error("run request not taken at the tick");

  a_stopped_reset_holds: assert property (
    (wr_rst && !running_q && !run_req_q) |=> ##1 (div_q == DIV_RST))
    else $error("cleared divider moved while stopped");

  a_rst_reads_zero: assert property (
    (setup && hit_ctl && !apb_req.pwrite) |=> !rsp_q.prdata[RST_BIT])
    else $error("timer reset bit did not read zero");

  a_prio_write: assert property (
    wr_prio |=> (prio_q == $past(apb_req.pwdata[PRIO_LSB +: 2])))
    else $error("priority field not taken from the write");

  a_level_follows: assert property (
    1'b1 |=> (irq_q.level == $past(prio_q)))
    else $error("request level does not follow the priority");

  a_enable_write: assert property (
    wr_en |=> (en_q == $past(apb_req.pwdata[SRC_LSB +: SRC_N])))
    else $error("enable bits not taken from the write");

  a_irq_disabled: assert property (
    ((pend_q & en_q) == '0) |=> !irq_q.req)
    else $error("request raised with no enabled pending flag");

  a_irq_raised: assert property (
    ((|(pend_q & en_q)) && (prio_q > cpu_mask)) |=> irq_q.req)
    else $error("request missing for an enabled pending flag");

  a_pend_8hz_set: assert property (
    fall[TAP_8HZ] |=> pend_q[1])
    else $error("8 Hz pending flag not set on falling edge");

  a_pend_2hz_set: assert property (
    fall[TAP_2HZ] |=> pend_q[2])
    else $error("2 Hz pending flag not set on falling edge");

  a_pend_1hz_set: assert property (
    fall[TAP_1HZ] |=> pend_q[3])
    else $error("1 Hz pending flag not set on falling edge");

  a_minute_no_false: assert property (
    (!wrap && !pend_q[SRC_N-1]) |=> !pend_q[SRC_N-1])
    else $error("minute flag set without a seconds wrap");

  a_pend_any_source: assert property (
    (|src_set) |=> ((pend_q & $past(src_set)) == $past(src_set)))
    else $error("pending flag not set by its source");

  a_pend_zero_keeps: assert property (
    (wr_pend && !apb_req.pwdata[SRC_LSB] && pend_q[0]) |=> pend_q[0])
    else $error("writing zero cleared a pending flag");

  a_units_step: assert property (
    (fall[TAP_1HZ] && (units_q != UNITS_MAX))
    |=> (units_q == 4'($past(units_q) + 1'b1)) && $stable(tens_q))
    else $error("seconds units did not step by one");

  a_tens_carry: assert property (
    (fall[TAP_1HZ] && (units_q == UNITS_MAX) && (tens_q != TENS_MAX))
    |=> (units_q == UNITS_RST) && (tens_q == 3'($past(tens_q) + 1'b1)))
    else $error("seconds units did not carry into tens");

  a_seconds_hold: assert property (
    (!fall[TAP_1HZ] && !clr_div) |=> $stable({tens_q, units_q}))
    else $error("seconds changed without a 1 Hz falling edge");

  a_vector_fixed: assert property (
    irq_q.vector == VECTOR_ADDR)
    else $error("exception vector is not the shared address");

  c_minute_wrap: cover property (wrap);
  c_irq_raised: cover property (!irq_q.req ##1 irq_q.req);
  c_stop_taken: cover property (running_q ##1 !running_q);
  c_unmapped: cover property (rsp_q.pready && rsp_q.pslverr);
  c_reset_running: cover property (wr_rst && running_q);

endmodule

// >>> clock_timer_pkg.sv
package clock_timer_pkg;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_PRIO = 16'hFF21;
  localparam logic [15:0] IDX_ENABLE = 16'hFF25;
  localparam logic [15:0] IDX_PENDING = 16'hFF29;
  localparam logic [15:0] IDX_CTRL = 16'hFF50;
  localparam logic [15:0] IDX_DIV = 16'hFF51;
  localparam logic [15:0] IDX_SEC = 16'hFF52;
  // Field positions
  localparam int unsigned RUN_BIT = 0;
  localparam int unsigned RST_BIT = 1;
  localparam int unsigned PRIO_LSB = 2;
  localparam int unsigned SRC_LSB = 3;
  localparam int unsigned SRC_N = 5;
  localparam int unsigned SEC_MSB = 6;
  localparam int unsigned TAP_32HZ = 2;
  localparam int unsigned TAP_8HZ = 4;
  localparam int unsigned TAP_2HZ = 6;
  localparam int unsigned TAP_1HZ = 7;
  // Reset values and constants
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [3:0] UNITS_RST = 4'h0;
  localparam logic [2:0] TENS_RST = 3'h0;
  localparam logic [1:0] PRIO_RST = 2'h0;
  localparam logic [3:0] UNITS_MAX = 4'h9;
  localparam logic [2:0] TENS_MAX = 3'h5;
  localparam logic [23:0] VECTOR_ADDR = 24'h000028;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_PERIOD_NS = 3906250;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic req;
    logic [1:0] level;
    logic [23:0] vector;
  } irq_out_t;
endpackage

// >>> cpu_model.sv
`timescale 1ns/1ps
module cpu_model
  import clock_timer_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Interrupt side
  input irq_out_t irq_out,
  input wire logic set_mask,
  input wire logic [1:0] mask_val,
  // Mask level and accepted count
  output logic cpu_mask_bit_low,
  output logic cpu_mask_bit_high,
  output logic [7:0] taken
);
  logic [1:0] mask_q;
  logic req_q;

  assign {cpu_mask_bit_high, cpu_mask_bit_low} = mask_q;

  // Accepting raises the mask to the request level, as the core does
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_q <= 2'h0;
      req_q <= 1'b0;
      taken <= 8'h00;
    end else begin
      req_q <= irq_out.req;
      if (irq_out.req && !req_q && irq_out.vector == VECTOR_ADDR) begin
        mask_q <= irq_out.level;
        taken <= taken + 8'h01;
      end else if (set_mask) begin
        mask_q <= mask_val;
      end
    end
  end
endmodule

// >>> clock_timer_seconds_counter_bench.sv
`timescale 1ns/1ps
module clock_timer_seconds_counter_bench
  import clock_timer_pkg::*;
  ;
  // Short tick keeps the wrap from the 59 s preset well inside the run
  localparam int TICKS = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  apb_req_t apb_req = '0;
  apb_rsp_t apb_rsp;
  irq_out_t irq_out;
  logic lo, hi, e;
  logic set_mask = 1'b0;
  logic [1:0] mask_val = 2'h0;
  logic [7:0] taken, q, q2;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  always #25 sys_clk = ~sys_clk;

  clock_timer_seconds_counter #(.TICK_CYCLES_P(TICKS)) dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .cpu_mask_bit_low(lo),
    .cpu_mask_bit_high(hi),
    .irq_out(irq_out)
  );

  cpu_model cpu (
    .sys_clk(sys_clk),
    .rst(rst),
    .irq_out(irq_out),
    .set_mask(set_mask),
    .mask_val(mask_val),
    .cpu_mask_bit_low(lo),
    .cpu_mask_bit_high(hi),
    .taken(taken)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Opens with an edge so a release is never followed in the same step
  task automatic xfer(input logic w, input logic [15:0] idx,
    input logic [7:0] d, output logic [7:0] rq, output logic err);
    @(posedge sys_clk);
    apb_req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, d}};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do @(posedge sys_clk); while (apb_rsp.pready !== 1'b1);
    rq = apb_rsp.prdata[7:0];
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, q, e);
    chk({7'h0, e}, 8'h00);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00, q, e);
    chk(q, exp);
  endtask

  task automatic mask_to_zero();
    set_mask <= 1'b1;
    @(posedge sys_clk);
    set_mask <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(IDX_PRIO, 8'h00);
    rd(IDX_ENABLE, 8'h00);
    rd(IDX_PENDING, 8'h00);
    rd(IDX_CTRL, 8'h00);
    rd(IDX_DIV, 8'h00);
    rd(IDX_SEC, 8'h00);
    xfer(1'b0, 16'hFF22, 8'h00, q, e);
    chk({7'h0, e}, 8'h01);
    wr(IDX_DIV, 8'hA5);
    rd(IDX_DIV, 8'h00);
    wr(IDX_PRIO, 8'h0C);
    rd(IDX_PRIO, 8'h0C);
    wr(IDX_ENABLE, 8'h80);
    rd(IDX_ENABLE, 8'h80);
    // Presets stay inside the legal BCD range
    wr(IDX_SEC, 8'h59);
    rd(IDX_SEC, 8'h59);
    wr(IDX_CTRL, 8'h01);
    n = 0;
    q2 = 8'h59;
    while (q2 !== 8'h00 && n < 2000) begin
      xfer(1'b0, IDX_SEC, 8'h00, q2, e);
      n++;
    end
    chk(q2, 8'h00);
    rd(IDX_PENDING, 8'hF8);
    chk(taken, 8'h01);
    chk({6'h0, irq_out.level}, 8'h03);
    chk({7'h0, irq_out.req}, 8'h00);
    // Flag left pending, so lowering the mask brings the request back
    mask_to_zero();
    chk(taken, 8'h02);
    wr(IDX_PENDING, 8'h00);
    rd(IDX_PENDING, 8'hF8);
    wr(IDX_PENDING, 8'h80);
    rd(IDX_PENDING, 8'h78);
    mask_to_zero();
    chk({7'h0, irq_out.req}, 8'h00);
    chk(taken, 8'h02);
    wr(IDX_ENABLE, 8'h08);
    repeat (4) @(posedge sys_clk);
    chk(taken, 8'h03);
    wr(IDX_CTRL, 8'h00);
    repeat (20) @(posedge sys_clk);
    rd(IDX_CTRL, 8'h00);
    xfer(1'b0, IDX_DIV, 8'h00, q2, e);
    repeat (40) @(posedge sys_clk);
    rd(IDX_DIV, q2);
    wr(IDX_SEC, 8'h12);
    rd(IDX_DIV, 8'h00);
    rd(IDX_SEC, 8'h12);
    wr(IDX_CTRL, 8'h01);
    repeat (100) @(posedge sys_clk);
    wr(IDX_CTRL, 8'h03);
    rd(IDX_CTRL, 8'h01);
    rd(IDX_SEC, 8'h00);
    // Reset while running: the divider must already count again
    xfer(1'b0, IDX_DIV, 8'h00, q2, e);
    chk({7'h0, q2 != 8'h00}, 8'h01);
    wr(IDX_CTRL, 8'h00);
    repeat (20) @(posedge sys_clk);
    wr(IDX_CTRL, 8'h02);
    repeat (20) @(posedge sys_clk);
    rd(IDX_DIV, 8'h00);
    results();
  end
endmodule
